// ===== hdl/lcdsb_top.sv
// LCD segment buffer words 13 to 19 and the display enable control
//
// Overview of operation
// - Odd segment upper nibble, even lower nibble
// - Words 13..19 hold pairs 26/27 to 38/39
// - Enable one closes supply switch, display active
// - Enable zero opens supply switch, display blank
// - Commons low when disabled, waveforms when enabled
// - Reset clears enable, supply off, commons low
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "lcdsb_consts.svh"
module lcdsb_top #(
  parameter int PHASE_CYCLES = `LCDSB_PHASE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic lcd_drive_supply_o,
  output logic [3:0] common_line_o,
  output logic [13:0] segment_o
);
  import lcdsb_pkg::*;

  localparam int NW = `LCDSB_BUF_WORDS;
  localparam int FW = `LCDSB_FIELD_W;

  logic [NW-1:0][7:0] buf_reg; // Segment pair words, lowest pair first
  logic enable_reg; // Display enable bit of control word zero
  logic [31:0] rdata_reg; // Read data, valid only after a read strobe
  logic supply_reg; // Drive supply switch
  logic [3:0] com_reg; // Common line levels
  logic [13:0] seg_reg; // Segment line levels
  lcdsb_phase_t phase; // Current common phase
  logic tick; // Phase step pulse
  logic [5:0] widx; // Word index of the bus address
  logic buf_hit; // Address falls inside the buffer words
  logic [2:0] buf_sel; // Buffer word number inside the block
  logic [1:0] com_idx; // Binary common number of the phase

  assign widx = addr_i[7:2];
  assign buf_hit = (widx >= `LCDSB_BUF_FIRST_IDX) &&
                   (widx <= `LCDSB_BUF_LAST_IDX);
  assign buf_sel = 3'(widx - `LCDSB_BUF_FIRST_IDX);

  // Gray phase to common number
  always_comb begin
    unique case (phase)
      LCDSB_PH0: com_idx = 2'h0;
      LCDSB_PH1: com_idx = 2'h1;
      LCDSB_PH2: com_idx = 2'h2;
      LCDSB_PH3: com_idx = 2'h3;
    endcase
  end

  // Segment levels for one common: bit k of each field drives common k
  function automatic logic [13:0] seg_pick(
    input logic [NW-1:0][7:0] words,
    input logic [1:0] ci
  );
    logic [13:0] s;
    s = '0;
    for (int i = 0; i < NW; i++) begin
      s[2*i] = words[i][`LCDSB_EVEN_LSB + ci];
      s[2*i+1] = words[i][`LCDSB_ODD_LSB + ci];
    end
    return s;
  endfunction

  // Scan timing lives in its own small module
  lcdsb_phase_gen #(
    .PHASE_CYCLES(PHASE_CYCLES)
  ) u_phase (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(enable_reg),
    .phase_o(phase),
    .tick_o(tick)
  );

  // One register per buffer word, each written only at its own index
  generate
    for (genvar g = 0; g < NW; g++) begin : g_buf
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          buf_reg[g] <= `LCDSB_BUF_RST;
        end else if (wr_i && buf_hit && buf_sel == 3'(g)) begin
          // Only the two nibbles are stored; bits 31..8 are read-only
          buf_reg[g] <= wdata_i[7:0];
        end
      end
    end
  endgenerate

  // Display enable; reset leaves the display switched off
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_reg <= `LCDSB_EN_RST;
    end else if (wr_i && widx == `LCDSB_CTRL_IDX) begin
      enable_reg <= wdata_i[`LCDSB_EN_BIT];
    end
  end

  // Read port; unmapped words and reserved bits read as zero
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (!rd_i) begin
      // Data stand for one cycle only
      rdata_reg <= '0;
    end else if (buf_hit) begin
      rdata_reg <= {24'h000000, buf_reg[buf_sel]};
    end else if (widx == `LCDSB_CTRL_IDX) begin
      rdata_reg <= {31'h00000000, enable_reg};
    end else if (widx == `LCDSB_STAT_IDX) begin
      rdata_reg <= {29'h00000000, com_idx, supply_reg};
    end else begin
      rdata_reg <= '0;
    end
  end

  // Supply switch follows the enable bit one cycle later
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_reg <= 1'b0;
    end else begin
      supply_reg <= enable_reg;
    end
  end

  // Commons: low while off, otherwise the scanned common is high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      com_reg <= 4'h0;
    end else if (!enable_reg) begin
      com_reg <= 4'h0;
    end else begin
      com_reg <= 4'h1 << com_idx;
    end
  end

  // Segments: blank while off, else the fields' bits for this common.
  // Levels here are logical; the analog bias network shapes voltages.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seg_reg <= '0;
    end else if (!enable_reg) begin
      seg_reg <= '0;
    end else begin
      seg_reg <= seg_pick(buf_reg, com_idx);
    end
  end

  assign rdata_o = rdata_reg;
  assign lcd_drive_supply_o = supply_reg;
  assign common_line_o = com_reg;
  assign segment_o = seg_reg;

  // Checks on the outputs against their causes
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  field_map_a: assert property (
    enable_reg |=> segment_o == seg_pick($past(buf_reg), $past(com_idx)))
    else $error("segment levels do not match buffer fields");

  last_word_a: assert property (
    rd_i && widx == `LCDSB_BUF_LAST_IDX
    |=> rdata_o == {24'h000000, $past(buf_reg[NW-1])})
    else $error("last buffer word read back wrong");

  write_back_a: assert property (
    wr_i && buf_hit ##1 rd_i && $past(addr_i) == addr_i
    |=> rdata_o == {24'h000000, $past(wdata_i[7:0], 2)})
    else $error("buffer write not seen on read back");

  supply_on_a: assert property (
    $rose(enable_reg) |=> lcd_drive_supply_o ##1 $onehot(common_line_o))
    else $error("supply or commons late after enable");

  supply_off_a: assert property (
    !enable_reg |=> !lcd_drive_supply_o && segment_o == 14'h0000)
    else $error("supply or segments active while disabled");

  com_low_a: assert property (
    !enable_reg |=> common_line_o == 4'h0)
    else $error("commons not low while disabled");

  com_scan_a: assert property (
    enable_reg && tick && phase == LCDSB_PH3 && $past(enable_reg)
    |=> ##1 common_line_o == 4'h1)
    else $error("common scan did not wrap to line zero");

  reset_off_a: assert property (
    $past(rst_i) |-> !enable_reg && !lcd_drive_supply_o &&
                     common_line_o == 4'h0)
    else $error("display not off after reset");

  enable_cov: cover property ($rose(lcd_drive_supply_o));
  wrap_cov: cover property (tick && phase == LCDSB_PH3);
  last_wr_cov: cover property (wr_i && widx == `LCDSB_BUF_LAST_IDX);
  disable_cov: cover property ($fell(enable_reg));

endmodule

// ===== inc/lcdsb_consts.svh
// Offsets, field positions, reset values and timing counts of the LCD buffer
`ifndef LCDSB_CONSTS_SVH
`define LCDSB_CONSTS_SVH

// Register word indices; the byte address is four times the index
`define LCDSB_CTRL_IDX 6'h00
`define LCDSB_STAT_IDX 6'h01
`define LCDSB_BUF_FIRST_IDX 6'h0D
`define LCDSB_BUF_LAST_IDX 6'h13
`define LCDSB_BUF_WORDS 7

// Field positions inside a buffer word
`define LCDSB_ODD_MSB 7
`define LCDSB_ODD_LSB 4
`define LCDSB_EVEN_MSB 3
`define LCDSB_EVEN_LSB 0
`define LCDSB_FIELD_W 4

// Control and status bit positions
`define LCDSB_EN_BIT 0
`define LCDSB_STAT_SUPPLY_BIT 0
`define LCDSB_STAT_PHASE_LSB 1

// Reset values
`define LCDSB_EN_RST 1'b0
`define LCDSB_BUF_RST 8'h00

// Common phase time and its cycle count at the core clock
`define LCDSB_CLK_PERIOD_NS 4
`define LCDSB_PHASE_TIME_US 1000
`define LCDSB_PHASE_CYCLES \
  ((`LCDSB_PHASE_TIME_US * 1000) / `LCDSB_CLK_PERIOD_NS)

`endif

// ===== inc/lcdsb_pkg.sv
// Types shared by the LCD segment buffer and its common phase generator
package lcdsb_pkg;

  // Common drive phase, Gray coded along the scan order
  typedef enum logic [1:0] {
    LCDSB_PH0 = 2'b00,
    LCDSB_PH1 = 2'b01,
    LCDSB_PH2 = 2'b11,
    LCDSB_PH3 = 2'b10
  } lcdsb_phase_t;

endpackage

// ===== hdl/lcdsb_phase_gen.sv
// Common line scan generator: phase divider and four-step phase sequencer
`timescale 1ns/1ns
`include "lcdsb_consts.svh"
module lcdsb_phase_gen #(
  parameter int PHASE_CYCLES = `LCDSB_PHASE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output lcdsb_pkg::lcdsb_phase_t phase_o,
  output logic tick_o
);
  import lcdsb_pkg::*;

  localparam int CW = $clog2(PHASE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PHASE_CYCLES - 1);

  logic [CW-1:0] div_reg; // Cycles spent in the current phase
  lcdsb_phase_t phase_reg; // Current common phase
  logic tick_reg; // One-cycle enable at each phase end

  // Divider; held clear while stopped so a restart gets a full phase
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (!run_i) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == LAST) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // Phase sequencer steps on each tick, parks on phase 0 when stopped
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= LCDSB_PH0;
    end else if (!run_i) begin
      phase_reg <= LCDSB_PH0;
    end else if (tick_reg) begin
      unique case (phase_reg)
        LCDSB_PH0: phase_reg <= LCDSB_PH1;
        LCDSB_PH1: phase_reg <= LCDSB_PH2;
        LCDSB_PH2: phase_reg <= LCDSB_PH3;
        LCDSB_PH3: phase_reg <= LCDSB_PH0;
      endcase
    end
  end

  assign phase_o = phase_reg;
  assign tick_o = tick_reg;

endmodule

// ===== test/lcdsb_panel.sv
// Glass model: remembers what each common line showed on the segments
`timescale 1ns/1ns
module lcdsb_panel (
  input wire logic core_clk_i,
  input wire logic supply_i,
  input wire logic [3:0] common_i,
  input wire logic [13:0] segment_i,
  output logic [55:0] lit_o
);
  // Segments show only under a single selected common while powered;
  // without supply the glass goes blank, so stale data cannot pass
  always @(posedge core_clk_i) begin
    if (!supply_i) begin
      lit_o <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (common_i == (4'h1 << c)) begin
          lit_o[c*14 +: 14] <= segment_i;
        end
      end
    end
  end
endmodule

// ===== test/lcd_segment_buffer_and_enable_tb_top.sv
// Self-checking bench for the LCD buffer words and display enable
`timescale 1ns/1ns
module lcd_segment_buffer_and_enable_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic supply;
  logic [3:0] common;
  logic [13:0] segment;
  logic [55:0] lit;
  logic [7:0] vals [7]; // Buffer patterns, the two nibbles of each word distinct
  int fails = 0;
  int check_count = 0;

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  // Short phase keeps a full scan within a few dozen cycles
  lcdsb_top #(.PHASE_CYCLES(4)) dut (.core_clk_i(core_clk), .rst_i(rst),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .lcd_drive_supply_o(supply),
    .common_line_o(common), .segment_o(segment));
  lcdsb_panel panel (.core_clk_i(core_clk), .supply_i(supply),
    .common_i(common), .segment_i(segment), .lit_o(lit));

  task automatic chk(input string n, input logic [55:0] s,
                     input logic [55:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One write strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Display off and every buffer word clear
  task automatic reset_values;
    logic [31:0] d;
    chk("supply", supply, 56'h0);
    chk("common", common, 56'h0);
    for (int k = 0; k < 7; k++) begin
      rd_reg(8'h34 + 8'(4 * k), d);
      chk("buf_rst", d, 56'h0);
    end
  endtask

  // Write strobe followed at once by a read strobe of the same word
  task automatic wr_rd_b2b(input logic [7:0] a, input logic [31:0] v,
                           output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Upper bits refused, both fields kept; unmapped word reads zero
  task automatic buffer_access;
    logic [31:0] d;
    wr_rd_b2b(8'h4C, 32'h0000005A, d);
    chk("buf_b2b", d, 56'h5A);
    for (int k = 0; k < 7; k++) begin
      wr_reg(8'h34 + 8'(4 * k), {24'hFFFFFF, vals[k]});
      rd_reg(8'h34 + 8'(4 * k), d);
      chk("buf_rw", d, {24'h0, vals[k]});
    end
    wr_reg(8'h50, 32'hFFFFFFFF);
    rd_reg(8'h50, d);
    chk("unmapped", d, 56'h0);
  endtask

  // Enable, let one full scan land on the glass, compare every pixel
  task automatic scan_check;
    logic [31:0] d;
    logic [55:0] exp;
    int i;
    wr_reg(8'h00, 32'h00000001);
    @(posedge core_clk);
    #1 chk("supply_on", supply, 56'h1);
    rd_reg(8'h00, d);
    chk("enable_rd", d, 56'h1);
    rd_reg(8'h04, d);
    chk("status_on", d[0], 56'h1);
    for (i = 0; i < 64 && common !== 4'b1000; i++) @(posedge core_clk);
    if (i == 64) begin
      fails++;
      finish_test();
    end
    @(posedge core_clk);
    #1;
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 14; j++) begin
        exp[c*14 + j] = vals[j / 2][(j % 2) * 4 + c];
      end
    end
    chk("lit", lit, exp);
  endtask

  // Clearing enable blanks the glass and parks commons low
  task automatic blank_check;
    logic [31:0] d;
    wr_reg(8'h00, 32'h00000000);
    repeat (2) @(posedge core_clk);
    #1 chk("supply_off", supply, 56'h0);
    chk("common_off", common, 56'h0);
    chk("blank", lit, 56'h0);
    rd_reg(8'h04, d);
    chk("status_off", d, 56'h0);
  endtask

  // Main sequence, ending with a reset on the same edge as an enable write, before the supply comes on
  initial begin
    vals = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h12, 8'hF0, 8'h69};
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    reset_values();
    buffer_access();
    scan_check();
    blank_check();
    wr_reg(8'h00, 32'h00000001);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1 reset_values();
    finish_test();
  end
endmodule
